// file: include/dele_defs.vh
// Constants for the data EEPROM latch and programming controller
`ifndef DELE_DEFS_VH
`define DELE_DEFS_VH
// Register byte offsets
`define DELE_OFF_EECS 8'h30
`define DELE_OFF_FPC 8'h34
`define DELE_OFF_OPT 8'h38
`define DELE_OFF_STAT 8'h3C
`define DELE_OFF_ICC 8'h40
// eeprom_ctrl_status fields
`define DELE_EECS_PGM 0
`define DELE_EECS_LAT 1
// flash_program_control fields and reset
`define DELE_FPC_PGM 0
`define DELE_FPC_LAT 1
`define DELE_FPC_OPT 2
`define DELE_FPC_RST 3'h0
// Unlock keys, written in this order
`define DELE_KEY1 8'h56
`define DELE_KEY2 8'hAE
// Option register fields
`define DELE_OPT_ROP 0
`define DELE_OPT_WEP 1
// Status register fields
`define DELE_ST_BUSY 0
`define DELE_ST_WAIT 1
`define DELE_ST_HALT 2
`define DELE_ST_ERASE 3
`define DELE_ST_UNLK 4
// Pin control register fields
`define DELE_ICC_OUT 0
`define DELE_ICC_OE 1
// Erased cell value
`define DELE_ERASED 8'hFF
// Timing: self-timed programming cycle
`define DELE_CLK_KHZ 20000
`define DELE_PROG_TIME_US 5000
// Cycle count of 5000 us at 20000 kHz, sized for the 20-bit timer
`define DELE_PROG_CYC 20'h186A0
// AHB transfer type
`define DELE_HTRANS_NSEQ 2'h2
`endif

// file: src/dele_mem.v
// Byte array of the data EEPROM with one write port and a registered read
`timescale 1ns/1ps
`default_nettype none
module dele_mem #(
  parameter DW = 8,
  parameter AW = 8
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  // Cells keep their content over reset, like the real array
  always @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // Read data from a register
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= {DW{1'b0}};
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule
`default_nettype wire

// file: src/dele_ctrl.v
// Data EEPROM access, latch programming, protection and unlock control
// Notes on behaviour
// R1 - Read mode: array byte served like ROM
// R2 - Instruction fetches from array are refused
// R3 - Software sets latch mode before any write
// R4 - Write mode: byte stored in latch by address
// R5 - Program start writes all held latches
// R6 - Row taken from last latched write address
// R7 - Cycle end clears both control bits together
// R8 - Latches clear at cycle end, latch-bit fall
// R9 - Latch contents never readable by CPU
// R10 - Read in write mode leaves bus undriven
// R11 - Write in read mode is discarded
// R12 - Wait entered when idle, after running cycle
// R13 - Active-halt behaves like wait
// R14 - Halt aborts everything at once
// R15 - Software must not interrupt running cycle
// R16 - Readout option blocks external read and rewrite
// R17 - Removing readout option erases memories first
// R18 - Write/erase option blocks flash writes forever; here a reset clears the option
// R19 - Flash control needs keys 56h then AEh
// R20 - Reset returns serial clock pin to pull-up input
// R21 - Programming tool alone drives reset
// R22 - Latch bit cleared only when program bit clear
// R23 - Reset clears latches and control bits
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dele_defs.vh"
module dele_ctrl #(
  parameter [19:0] PROG_CYCLES = `DELE_PROG_CYC,
  parameter LAT_AW = 5,
  parameter MEM_AW = 8
) (
  input wire CORE_CLK_I,
  input wire RST_N_I,
  input wire HSEL_I,
  input wire [31:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg [31:0] HRDATA_O,
  output reg HREADYOUT_O,
  output reg HRESP_O,
  input wire MEM_SEL_I,
  input wire MEM_WR_I,
  input wire MEM_FETCH_I,
  input wire [MEM_AW-1:0] MEM_ADDR_I,
  input wire [7:0] MEM_WDATA_I,
  output wire [7:0] MEM_RDATA_O,
  output reg MEM_RDATA_OE_O,
  input wire EXT_ACCESS_I,
  input wire WFI_I,
  input wire ACTIVE_HALT_I,
  input wire HALT_I,
  output reg WAIT_ACK_O,
  output reg HALT_ACK_O,
  output reg [2:0] FLASH_CTRL_O,
  output reg FLASH_WR_BLOCK_O,
  output reg FLASH_RD_BLOCK_O,
  output reg FLASH_ERASE_O,
  output reg ICC_CLK_O,
  output reg ICC_CLK_OE_O,
  output reg ICC_CLK_PU_O
);
  localparam LATCH_N = 1 << LAT_AW;
  localparam ROW_W = MEM_AW - LAT_AW;
  localparam [19:0] PROG_LAST = PROG_CYCLES - 20'h00001;
  // One-hot states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_TIME = 4'h2;
  localparam [3:0] ST_COMMIT = 4'h4;
  localparam [3:0] ST_ERASE = 4'h8;

  // Register hit on a word offset
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr[7:2] == off[7:2]);
    end
  endfunction

  reg [3:0] state_r;
  reg lat_r;
  reg pgm_r;
  reg [LATCH_N-1:0] valid_r;
  reg [7:0] latch_r [0:LATCH_N-1];
  reg [ROW_W-1:0] row_r;
  reg [19:0] tmr_r;
  reg [MEM_AW-1:0] idx_r;
  reg [2:0] fpc_r;
  reg [1:0] key_st_r;
  reg rop_r;
  reg wep_r;
  reg icc_out_r;
  reg icc_oe_r;
  reg wait_r;
  reg halt_r;
  reg dph_wr_r;
  reg [7:0] dph_addr_r;
  reg arr_we;
  reg [MEM_AW-1:0] arr_waddr;
  reg [7:0] arr_wdata;
  reg [31:0] rd_mux;

  wire ahb_req = HSEL_I && HREADY_I && (HTRANS_I == `DELE_HTRANS_NSEQ);
  wire [7:0] wd = HWDATA_I[7:0];
  wire wr_eecs = dph_wr_r && hit(dph_addr_r, `DELE_OFF_EECS);
  wire wr_fpc = dph_wr_r && hit(dph_addr_r, `DELE_OFF_FPC);
  wire wr_opt = dph_wr_r && hit(dph_addr_r, `DELE_OFF_OPT);
  wire wr_icc = dph_wr_r && hit(dph_addr_r, `DELE_OFF_ICC);
  wire unlocked = (key_st_r == 2'h2);
  // External tools lose all access while readout protection is on
  wire ext_block = rop_r && EXT_ACCESS_I; // R16
  wire mem_rd = MEM_SEL_I && !MEM_WR_I;
  wire mem_wr = MEM_SEL_I && MEM_WR_I && lat_r && !ext_block && !HALT_I; // R4 R11 R14
  wire [LAT_AW-1:0] lat_sel = MEM_ADDR_I[LAT_AW-1:0];
  wire stop_req = WFI_I || ACTIVE_HALT_I;
  wire cyc_end = state_r[2] && (idx_r[LAT_AW-1:0] == {LAT_AW{1'b1}});
  wire erase_end = state_r[3] && (idx_r == {MEM_AW{1'b1}});
  // Software start only from idle, not while stopping or in wait
  wire start = wr_eecs && wd[`DELE_EECS_PGM] && lat_r && !pgm_r && state_r[0] && !stop_req;
  // Software clear of the program bit kills the cycle; data not guaranteed
  wire sw_abort = wr_eecs && !wd[`DELE_EECS_PGM] && pgm_r; // R15
  wire lat_fall = lat_r && (wr_eecs && !wd[`DELE_EECS_LAT] && !pgm_r); // R22

  // AHB-Lite address phase capture; word transfers only
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 8'h00;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      dph_wr_r <= ahb_req && HWRITE_I;
      if (ahb_req) begin
        dph_addr_r <= HADDR_I[7:0];
      end
      HREADYOUT_O <= 1'b1; // Never stretches a transfer
      HRESP_O <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero, latches never appear here
  always @* begin
    rd_mux = 32'h00000000; // R9
    if (hit(HADDR_I[7:0], `DELE_OFF_EECS)) begin
      rd_mux[`DELE_EECS_LAT] = lat_r;
      rd_mux[`DELE_EECS_PGM] = pgm_r;
    end else if (hit(HADDR_I[7:0], `DELE_OFF_FPC)) begin
      rd_mux[2:0] = fpc_r;
    end else if (hit(HADDR_I[7:0], `DELE_OFF_OPT)) begin
      rd_mux[`DELE_OPT_ROP] = rop_r;
      rd_mux[`DELE_OPT_WEP] = wep_r;
    end else if (hit(HADDR_I[7:0], `DELE_OFF_STAT)) begin
      rd_mux[`DELE_ST_BUSY] = !state_r[0];
      rd_mux[`DELE_ST_WAIT] = wait_r;
      rd_mux[`DELE_ST_HALT] = halt_r;
      rd_mux[`DELE_ST_ERASE] = state_r[3];
      rd_mux[`DELE_ST_UNLK] = unlocked;
    end else if (hit(HADDR_I[7:0], `DELE_OFF_ICC)) begin
      rd_mux[`DELE_ICC_OUT] = icc_out_r;
      rd_mux[`DELE_ICC_OE] = icc_oe_r;
    end
  end

  // Read data registered in the address phase, stands in the data phase
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h00000000;
    end else if (ahb_req && !HWRITE_I) begin
      HRDATA_O <= rd_mux;
    end
  end

  // Control bits and programming sequencer
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= ST_IDLE; // R23
      lat_r <= 1'b0;
      pgm_r <= 1'b0;
      tmr_r <= 20'h00000;
      idx_r <= {MEM_AW{1'b0}};
    end else if (HALT_I) begin
      state_r <= ST_IDLE; // R14
      pgm_r <= 1'b0;
      lat_r <= 1'b0;
      tmr_r <= 20'h00000;
      idx_r <= {MEM_AW{1'b0}};
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wr_eecs) begin
            // Setting latch mode alone enters write mode
            if (wd[`DELE_EECS_LAT]) begin
              lat_r <= 1'b1;
            end else if (!pgm_r) begin
              lat_r <= 1'b0; // R22
            end
          end
          if (start) begin
            pgm_r <= 1'b1; // R5
            tmr_r <= 20'h00000;
            state_r <= ST_TIME;
          end else if (wr_opt && rop_r && !wd[`DELE_OPT_ROP]) begin
            idx_r <= {MEM_AW{1'b0}};
            state_r <= ST_ERASE; // R17
          end
        end
        ST_TIME: begin
          if (sw_abort) begin
            pgm_r <= 1'b0;
            lat_r <= 1'b0;
            state_r <= ST_IDLE;
          end else if (tmr_r == PROG_LAST) begin
            idx_r <= {MEM_AW{1'b0}};
            state_r <= ST_COMMIT;
          end else begin
            tmr_r <= tmr_r + 20'h00001;
          end
        end
        ST_COMMIT: begin
          if (cyc_end || sw_abort) begin
            pgm_r <= 1'b0; // R7
            lat_r <= 1'b0; // R7
            state_r <= ST_IDLE;
          end else begin
            idx_r <= idx_r + {{(MEM_AW-1){1'b0}}, 1'b1};
          end
        end
        ST_ERASE: begin
          if (erase_end) begin
            state_r <= ST_IDLE;
          end else begin
            idx_r <= idx_r + {{(MEM_AW-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Data latches; a repeat write ANDs into the held byte
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      valid_r <= {LATCH_N{1'b0}}; // R23
      row_r <= {ROW_W{1'b0}};
    end else if (HALT_I || cyc_end || lat_fall || sw_abort) begin
      valid_r <= {LATCH_N{1'b0}}; // R8
    end else if (mem_wr) begin
      valid_r[lat_sel] <= 1'b1; // R4
      row_r <= MEM_ADDR_I[MEM_AW-1:LAT_AW]; // R6
    end
  end

  // Latch byte store; invalid entries are overwritten, valid ones ANDed
  genvar gi;
  generate
    for (gi = 0; gi < LATCH_N; gi = gi + 1) begin : g_lat
      always @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          latch_r[gi] <= `DELE_ERASED;
        end else if (mem_wr && ({{(32-LAT_AW){1'b0}}, lat_sel} == gi)) begin
          latch_r[gi] <= valid_r[gi] ? (latch_r[gi] & MEM_WDATA_I) : MEM_WDATA_I; // R8
        end
      end
    end
  endgenerate

  // Array write port: latch commit or full erase
  always @* begin
    arr_we = 1'b0;
    arr_waddr = idx_r;
    arr_wdata = `DELE_ERASED;
    if (state_r[2] && !HALT_I) begin
      arr_we = valid_r[idx_r[LAT_AW-1:0]]; // R5
      arr_waddr = {row_r, idx_r[LAT_AW-1:0]}; // R6
      arr_wdata = latch_r[idx_r[LAT_AW-1:0]];
    end else if (state_r[3] && !HALT_I) begin
      arr_we = 1'b1; // R17
    end
  end

  dele_mem #(
    .DW(8),
    .AW(MEM_AW)
  ) u_mem (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .we_i(arr_we),
    .waddr_i(arr_waddr),
    .wdata_i(arr_wdata),
    .raddr_i(MEM_ADDR_I),
    .rdata_o(MEM_RDATA_O)
  );

  // Bus drive for array reads; data registered inside the array module
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MEM_RDATA_OE_O <= 1'b0;
    end else begin
      // Fetches are never served, so code cannot run from the array
      // Halt input used directly so the first halted cycle is already silent
      MEM_RDATA_OE_O <= mem_rd && !lat_r && !MEM_FETCH_I && !ext_block && !HALT_I; // R1 R2 R10 R14
    end
  end

  // Low-power handshakes
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wait_r <= 1'b0;
      halt_r <= 1'b0;
      WAIT_ACK_O <= 1'b0;
      HALT_ACK_O <= 1'b0;
    end else begin
      halt_r <= HALT_I; // R14
      HALT_ACK_O <= HALT_I;
      // A running cycle holds off the wait state until it ends
      wait_r <= stop_req && state_r[0] && !start; // R12 R13
      WAIT_ACK_O <= stop_req && state_r[0] && !start;
    end
  end

  // Key sequence: 56h then AEh opens the flash control register
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      key_st_r <= 2'h0;
      fpc_r <= `DELE_FPC_RST;
    end else if (wr_fpc) begin
      if (unlocked) begin
        fpc_r <= wd[2:0];
        // Program/erase refused once write protection is set, until the next reset
        if (wep_r) begin
          fpc_r[`DELE_FPC_PGM] <= 1'b0; // R18
        end
      end else if (key_st_r == 2'h0) begin
        key_st_r <= (wd == `DELE_KEY1) ? 2'h1 : 2'h0; // R19
      end else begin
        key_st_r <= (wd == `DELE_KEY2) ? 2'h2 : 2'h0; // R19
      end
    end
  end

  // Protection options; write protection can only be set
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rop_r <= 1'b0;
      wep_r <= 1'b0;
    end else begin
      if (wr_opt && wd[`DELE_OPT_WEP]) begin
        wep_r <= 1'b1; // R18
      end
      if (wr_opt && wd[`DELE_OPT_ROP]) begin
        rop_r <= 1'b1; // R16
      end else if (erase_end) begin
        rop_r <= 1'b0; // R17
      end
    end
  end

  // Flash-side outputs
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      FLASH_CTRL_O <= `DELE_FPC_RST;
      FLASH_WR_BLOCK_O <= 1'b0;
      FLASH_RD_BLOCK_O <= 1'b0;
      FLASH_ERASE_O <= 1'b0;
    end else begin
      FLASH_CTRL_O <= fpc_r;
      FLASH_WR_BLOCK_O <= wep_r || ext_block; // R16 R18
      FLASH_RD_BLOCK_O <= ext_block; // R16
      FLASH_ERASE_O <= state_r[3] && !erase_end; // R17
    end
  end

  // Serial clock pin; any reset puts it back to pulled-up input
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      icc_out_r <= 1'b0;
      icc_oe_r <= 1'b0; // R20
      ICC_CLK_O <= 1'b0;
      ICC_CLK_OE_O <= 1'b0;
      ICC_CLK_PU_O <= 1'b1; // R20
    end else begin
      if (wr_icc) begin
        icc_out_r <= wd[`DELE_ICC_OUT];
        icc_oe_r <= wd[`DELE_ICC_OE];
      end
      ICC_CLK_O <= icc_out_r;
      ICC_CLK_OE_O <= icc_oe_r;
      ICC_CLK_PU_O <= !icc_oe_r;
    end
  end
endmodule
`default_nettype wire

// file: verification/dele_monitor.sv
// Port checker for the data EEPROM controller
`timescale 1ns/1ps
`default_nettype none
module dele_monitor (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic MEM_SEL_I,
  input wire logic MEM_WR_I,
  input wire logic MEM_FETCH_I,
  input wire logic MEM_RDATA_OE_O,
  input wire logic EXT_ACCESS_I,
  input wire logic WFI_I,
  input wire logic ACTIVE_HALT_I,
  input wire logic HALT_I,
  input wire logic WAIT_ACK_O,
  input wire logic HALT_ACK_O,
  input wire logic FLASH_WR_BLOCK_O,
  input wire logic FLASH_RD_BLOCK_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Array read requested this cycle
  wire rd = MEM_SEL_I && !MEM_WR_I;
  a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus stalled or errored");
  a_drive_cause: assert property (MEM_RDATA_OE_O |->
    $past(rd && !MEM_FETCH_I && !HALT_I)) else $error("data driven without read");
  a_fetch_undriven: assert property (rd && MEM_FETCH_I |=> !MEM_RDATA_OE_O)
    else $error("fetch answered");
  a_halt_undriven: assert property (rd && HALT_I |=> !MEM_RDATA_OE_O)
    else $error("read answered in halt");
  a_halt_ack: assert property (HALT_ACK_O == $past(HALT_I))
    else $error("halt ack off");
  a_ext_undriven: assert property (rd && EXT_ACCESS_I && FLASH_RD_BLOCK_O
    |=> !MEM_RDATA_OE_O) else $error("protected read answered");
  a_block_pair: assert property (FLASH_RD_BLOCK_O |-> FLASH_WR_BLOCK_O)
    else $error("read block without write block");
  a_block_cause: assert property (FLASH_RD_BLOCK_O |-> $past(EXT_ACCESS_I))
    else $error("read block without tool access");
  a_wait_cause: assert property ($rose(WAIT_ACK_O) |->
    $past(WFI_I || ACTIVE_HALT_I)) else $error("wait without request");
endmodule
bind dele_ctrl dele_monitor mon_u (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .MEM_SEL_I(MEM_SEL_I),
  .MEM_WR_I(MEM_WR_I), .MEM_FETCH_I(MEM_FETCH_I), .MEM_RDATA_OE_O(MEM_RDATA_OE_O),
  .EXT_ACCESS_I(EXT_ACCESS_I), .WFI_I(WFI_I), .ACTIVE_HALT_I(ACTIVE_HALT_I),
  .HALT_I(HALT_I), .WAIT_ACK_O(WAIT_ACK_O), .HALT_ACK_O(HALT_ACK_O),
  .FLASH_WR_BLOCK_O(FLASH_WR_BLOCK_O), .FLASH_RD_BLOCK_O(FLASH_RD_BLOCK_O));
`default_nettype wire

// file: verification/dele_cpu_model.sv
// Behavioural CPU core on the array side of the controller
`timescale 1ns/1ps
`default_nettype none
module dele_cpu_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic oe_i,
  output logic sel_o,
  output logic wr_o,
  output logic fch_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial {sel_o, wr_o, fch_o, addr_o, wdata_o} = 19'h00000;
  // One request edge, byte and enable taken one cycle on
  task automatic acc(input logic w, f, input logic [7:0] a, d, output logic [7:0] q,
    output logic e);
    sel_o <= 1'h1;
    wr_o <= w;
    fch_o <= f;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    sel_o <= 1'h0;
    // Idle bus flips so a stale byte never looks valid
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge clk_i);
    q = rdata_i;
    e = oe_i;
  endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench of the data EEPROM controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_n, hwrite, ext, wait_for_interrupt_instr, ahalt, halt, sel, wr, fch, oe, rdy, resp, e;
  logic wack, hack, wblk, rblk, ers, ioe, ipu, ico;
  logic [1:0] htrans;
  logic [2:0] fctl;
  logic [7:0] ma, mw, mr, q;
  logic [31:0] haddr, hwdata, hrdata, r;
  // Write address, byte, read address, expected byte
  logic [31:0] rows [5] = '{32'h05772577, 32'h20A520A5, 32'h21F02130, 32'h213C2130,
    32'h3F5A3F5A};
  int n_mismatch = 0;
  int checks_done = 0;
  dele_ctrl #(.PROG_CYCLES(20'h00014)) dut_u (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'h1), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(rdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(rdy), .HRESP_O(resp), .MEM_SEL_I(sel), .MEM_WR_I(wr), .MEM_FETCH_I(fch),
    .MEM_ADDR_I(ma), .MEM_WDATA_I(mw), .MEM_RDATA_O(mr), .MEM_RDATA_OE_O(oe),
    .EXT_ACCESS_I(ext), .WFI_I(wait_for_interrupt_instr), .ACTIVE_HALT_I(ahalt), .HALT_I(halt), .WAIT_ACK_O(wack),
    .HALT_ACK_O(hack), .FLASH_CTRL_O(fctl), .FLASH_WR_BLOCK_O(wblk), .FLASH_RD_BLOCK_O(rblk),
    .FLASH_ERASE_O(ers), .ICC_CLK_O(ico), .ICC_CLK_OE_O(ioe), .ICC_CLK_PU_O(ipu));
  dele_cpu_model cpu_u (.clk_i(clk), .rdata_i(mr), .oe_i(oe), .sel_o(sel), .wr_o(wr),
    .fch_o(fch), .addr_o(ma), .wdata_o(mw));
  // 20 MHz clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Run needs some 500 cycles; cut a hang well beyond
  initial begin
    #1000000;
    n_mismatch++;
    close_out();
  end
  task automatic ck(input logic [31:0] g, x);
    checks_done++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected %0t got %h want %h", $time, g, x);
    end
  endtask
  // Single AHB word; called just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge clk);
    while (rdy !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge clk);
    while (rdy !== 1'h1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic rg(input logic [7:0] a);
    ahb(1'h0, a, 8'h00);
  endtask
  task automatic wm(input logic [7:0] a, d);
    cpu_u.acc(1'h1, 1'h0, a, d, q, e);
  endtask
  task automatic rm(input logic [7:0] a);
    cpu_u.acc(1'h0, 1'h0, a, 8'h00, q, e);
  endtask
  // Poll a status bit until it drops
  task automatic idle(input int b);
    do rg(8'h3C);
    while (r[b] !== 1'h0);
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_n, hwrite, ext, wait_for_interrupt_instr, ahalt, halt, htrans, haddr, hwdata} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rg(8'h30);
    ck(r, 32'h0);
    ck({ioe, ipu}, 2'h1);
    ahb(1'h1, 8'h30, 8'h02);
    foreach (rows[k]) wm(rows[k][31:24], rows[k][23:16]);
    ahb(1'h1, 8'h30, 8'h03);
    idle(0);
    rg(8'h30);
    ck(r, 32'h0);
    foreach (rows[k]) begin
      rm(rows[k][15:8]);
      ck({e, q}, {1'h1, rows[k][7:0]});
    end
    wm(8'h20, 8'h11);
    ahb(1'h1, 8'h30, 8'h02);
    wm(8'h21, 8'h00);
    rm(8'h21);
    ck(e, 1'h0);
    ahb(1'h1, 8'h30, 8'h00);
    rg(8'h30);
    ck(r, 32'h0);
    cpu_u.acc(1'h0, 1'h1, 8'h20, 8'h00, q, e);
    ck(e, 1'h0);
    ahb(1'h1, 8'h30, 8'h02);
    ahb(1'h1, 8'h30, 8'h03);
    wait_for_interrupt_instr <= 1'h1;
    ahb(1'h1, 8'h30, 8'h01);
    rg(8'h30);
    ck({wack, r[1:0]}, 3'h3);
    idle(0);
    repeat (2) @(posedge clk);
    ck(wack, 1'h1);
    wait_for_interrupt_instr <= 1'h0;
    repeat (2) @(posedge clk);
    ahalt <= 1'h1;
    repeat (2) @(posedge clk);
    ck(wack, 1'h1);
    ahalt <= 1'h0;
    repeat (2) @(posedge clk);
    rm(8'h20);
    ck(q, 8'hA5);
    rm(8'h21);
    ck(q, 8'h30);
    ahb(1'h1, 8'h30, 8'h02);
    ahb(1'h1, 8'h30, 8'h03);
    halt <= 1'h1;
    rm(8'h20);
    ck({e, hack}, 2'h1);
    halt <= 1'h0;
    rg(8'h30);
    ck(r, 32'h0);
    // Read in the very first halted cycle, read mode, must stay undriven
    halt <= 1'h1;
    rm(8'h20);
    ck(e, 1'h0);
    halt <= 1'h0;
    ahb(1'h1, 8'h34, 8'h07);
    repeat (2) @(posedge clk);
    ck(fctl, 3'h0);
    ahb(1'h1, 8'h34, 8'h56);
    ahb(1'h1, 8'h34, 8'hAE);
    ahb(1'h1, 8'h34, 8'h07);
    repeat (2) @(posedge clk);
    ck(fctl, 3'h7);
    ahb(1'h1, 8'h38, 8'h03);
    ahb(1'h1, 8'h34, 8'h07);
    ext <= 1'h1;
    repeat (2) @(posedge clk);
    ck({wblk, fctl}, 4'hE);
    rm(8'h20);
    ck({e, rblk}, 2'h1);
    ext <= 1'h0;
    ahb(1'h1, 8'h38, 8'h00);
    repeat (2) @(posedge clk);
    ck(ers, 1'h1);
    idle(3);
    rm(8'h20);
    ck({e, q}, 9'h1FF);
    ck(wblk, 1'h1);
    // Unmapped place reads zero
    rg(8'h50);
    ck(r, 32'h0);
    ahb(1'h1, 8'h40, 8'h03);
    ahb(1'h1, 8'h30, 8'h02);
    ck({ico, ioe}, 2'h3);
    rst_n <= 1'h0;
    @(posedge clk);
    ck({ico, ioe, ipu}, 3'h1);
    rst_n <= 1'h1;
    @(posedge clk);
    rg(8'h30);
    ck(r, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
